// file: design/epm_pin_mux.sv
// eeprom pin mux, reset handling, first-read gate, wake and speed strap
`timescale 1ns/1ps
module epm_pin_mux #(
  parameter int POR_TICKS = epm_pkg::EPM_POR_TICKS
) (
  // clock and internal power-on reset
  input  wire logic                       clock_i,
  input  wire logic                       rst_i,
  // board pins: reset, host strobes, strap
  input  wire logic                       hardware_reset_n_i,
  input  wire logic                       chip_select_n_i,
  input  wire logic                       write_strobe_n_i,
  input  wire logic                       read_strobe_n_i,
  input  wire logic                       speed_select_i,
  // eeprom data pin (two-way), clock pin, select pin
  input  wire logic                       eeprom_data_pin_i,
  output logic                            eeprom_data_pin_o,
  output logic                            eeprom_data_pin_oe_o,
  output logic                            eeprom_clock_pin_o,
  output logic                            eeprom_select_o,
  // internal eeprom controller
  input  wire epm_pkg::epm_ee_core_t      ee_core_i,
  output logic                            ee_data_in_o,
  // internal mii signals to monitor
  input  wire logic                       mii_tx_en_i,
  input  wire logic                       mii_tx_clk_i,
  input  wire logic                       mii_rx_dv_i,
  input  wire logic                       mii_rx_clk_i,
  // pin function configuration
  input  wire logic                       cfg_load_i,
  input  wire epm_pkg::epm_pin_cfg_t      data_pin_cfg_i,
  input  wire epm_pkg::epm_pin_cfg_t      clock_pin_cfg_i,
  // power management
  input  wire logic                       power_save_enter_i,
  input  wire logic                       wake_event_i,
  input  wire logic                       wake_enable_i,
  input  wire logic                       wake_active_high_i,
  input  wire logic                       wake_open_drain_i,
  input  wire logic                       wake_clear_i,
  output logic                            wake_indicator_o,
  output logic                            wake_indicator_oe_o,
  output logic                            power_save_o,
  // host access status
  output logic                            core_reset_o,
  output logic                            read_seen_o,
  output logic                            write_accept_o,
  output logic                            wake_write_o,
  // latched default ethernet settings
  output epm_pkg::epm_eth_defaults_t      eth_defaults_o
);

  // synchronised pin levels
  logic [epm_pkg::EPM_SYNC_W-1:0] pins_async;
  logic [epm_pkg::EPM_SYNC_W-1:0] pins_sync;

  // gather every asynchronous input into one synchroniser
  assign pins_async = {mii_rx_clk_i, mii_rx_dv_i, mii_tx_clk_i,
                       mii_tx_en_i, eeprom_data_pin_i, speed_select_i,
                       read_strobe_n_i, write_strobe_n_i, chip_select_n_i,
                       hardware_reset_n_i};

  epm_sync2 #(
    .WIDTH     (epm_pkg::EPM_SYNC_W),
    .RESET_VAL (epm_pkg::EPM_SYNC_RESET)
  ) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i (pins_async),
    .sync_o  (pins_sync)
  );

  // named views of the synchronised pins
  wire hw_rst_n_s = pins_sync[epm_pkg::EPM_S_HW_RST_N];
  wire cs_n_s     = pins_sync[epm_pkg::EPM_S_CS_N];
  wire wr_n_s     = pins_sync[epm_pkg::EPM_S_WR_N];
  wire rd_n_s     = pins_sync[epm_pkg::EPM_S_RD_N];
  wire speed_s    = pins_sync[epm_pkg::EPM_S_SPEED];
  wire ee_din_s   = pins_sync[epm_pkg::EPM_S_EE_DIN];
  wire tx_en_s    = pins_sync[epm_pkg::EPM_S_TX_EN];
  wire tx_clk_s   = pins_sync[epm_pkg::EPM_S_TX_CLK];
  wire rx_dv_s    = pins_sync[epm_pkg::EPM_S_RX_DV];
  wire rx_clk_s   = pins_sync[epm_pkg::EPM_S_RX_CLK];

  // reference-rate divider and power-on stretch
  localparam int DIV_W = $clog2(epm_pkg::EPM_REF_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST =
    DIV_W'(epm_pkg::EPM_REF_DIV - 1);
  localparam int POR_W = $clog2(POR_TICKS + 1);
  localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_TICKS);

  logic [DIV_W-1:0] div_reg;
  logic [POR_W-1:0] por_reg;
  logic             core_rst_reg;
  logic             rst_prev_reg;

  wire ref_tick = (div_reg == DIV_LAST);
  wire por_busy = (por_reg != POR_LAST);

  // 25 MHz reference tick from the 100 MHz clock
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      div_reg <= '0;
    end else begin
      div_reg <= ref_tick ? '0 : div_reg + 1'b1;
    end
  end

  // power-on stretch counted in reference ticks
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      por_reg <= '0;
    end else if (por_busy && ref_tick) begin
      por_reg <= por_reg + 1'b1;
    end
  end

  // internal reset: power-on stretch or hardware reset pin
  wire core_rst_next = por_busy | ~hw_rst_n_s;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      core_rst_reg <= 1'b1;
      rst_prev_reg <= 1'b1;
    end else begin
      core_rst_reg <= core_rst_next;
      rst_prev_reg <= core_rst_reg;
    end
  end

  // one-cycle pulse when the internal reset releases
  wire rst_release = rst_prev_reg & ~core_rst_reg;

  // speed strap latch
  epm_pkg::epm_eth_defaults_t eth_reg;
  wire epm_pkg::epm_eth_defaults_t eth_next =
    speed_s ? epm_pkg::EPM_DEFAULTS_100 : epm_pkg::EPM_DEFAULTS_10;

  // strap is caught by a clocked process at reset release
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      eth_reg <= epm_pkg::EPM_DEFAULTS_100;
    end else if (rst_release) begin
      eth_reg <= eth_next;
    end
  end

  // host strobe decoding and edge detection
  logic wr_cyc_prev_reg;
  logic rd_cyc_prev_reg;
  wire  wr_cyc   = ~cs_n_s & ~wr_n_s;
  wire  rd_cyc   = ~cs_n_s & ~rd_n_s;
  wire  wr_start = wr_cyc & ~wr_cyc_prev_reg;
  wire  rd_start = rd_cyc & ~rd_cyc_prev_reg;

  always_ff @(posedge clock_i) begin
    if (core_rst_reg) begin
      wr_cyc_prev_reg <= 1'b0;
      rd_cyc_prev_reg <= 1'b0;
    end else begin
      wr_cyc_prev_reg <= wr_cyc;
      rd_cyc_prev_reg <= rd_cyc;
    end
  end

  // power state machine
  typedef enum logic [0:0] {
    ST_ACTIVE,
    ST_SLEEP
  } epm_pwr_t;

  epm_pwr_t pwr_reg;
  epm_pwr_t pwr_next;
  logic     wake_now;

  // leave sleep only on a host write cycle or a core reset, never on wake events
  always_comb begin
    pwr_next = pwr_reg;
    wake_now = 1'b0;
    case (pwr_reg)
      ST_ACTIVE: begin
        if (power_save_enter_i) begin
          pwr_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wr_start) begin
          pwr_next = ST_ACTIVE;
          wake_now = 1'b1;
        end
      end
      default: begin
        pwr_next = ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (core_rst_reg) begin
      pwr_reg <= ST_ACTIVE;
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  // first-read gate: cleared by reset and by leaving sleep
  logic read_seen_reg;
  logic write_accept_reg;
  logic wake_write_reg;
  wire  active   = (pwr_reg == ST_ACTIVE);
  wire  wr_allow = wr_start & active & read_seen_reg;

  always_ff @(posedge clock_i) begin
    if (core_rst_reg) begin
      read_seen_reg <= 1'b0;
    end else if (wake_now) begin
      read_seen_reg <= 1'b0;
    end else if (rd_start && active) begin
      read_seen_reg <= 1'b1;
    end
  end

  // write acceptance and wake write pulses
  always_ff @(posedge clock_i) begin
    if (core_rst_reg) begin
      write_accept_reg <= 1'b0;
      wake_write_reg   <= 1'b0;
    end else begin
      write_accept_reg <= wr_allow;
      wake_write_reg   <= wake_now;
    end
  end

  // wake indicator: sticky, set wins over clear
  logic wake_pend_reg;
  logic wake_out_reg;
  logic wake_oe_reg;
  wire  wake_set = wake_event_i & wake_enable_i;

  always_ff @(posedge clock_i) begin
    if (core_rst_reg) begin
      wake_pend_reg <= 1'b0;
    end else if (wake_set) begin
      wake_pend_reg <= 1'b1;
    end else if (wake_clear_i || wake_now) begin
      wake_pend_reg <= 1'b0;
    end
  end

  // polarity and drive type of the wake pin
  wire wake_lvl   = wake_active_high_i ? wake_pend_reg : ~wake_pend_reg;
  wire wake_od_lv = wake_active_high_i;
  wire wake_o_nx  = wake_open_drain_i ? wake_od_lv : wake_lvl;
  wire wake_oe_nx = wake_open_drain_i ? wake_pend_reg : 1'b1;

  always_ff @(posedge clock_i) begin
    if (core_rst_reg) begin
      wake_out_reg <= 1'b0;
      wake_oe_reg  <= 1'b0;
    end else begin
      wake_out_reg <= wake_o_nx;
      wake_oe_reg  <= wake_oe_nx;
    end
  end

  // pin function configuration, eeprom after reset
  epm_pkg::epm_pin_cfg_t data_cfg_reg;
  epm_pkg::epm_pin_cfg_t clk_cfg_reg;

  always_ff @(posedge clock_i) begin
    if (core_rst_reg) begin
      data_cfg_reg <= epm_pkg::EPM_PIN_CFG_RESET;
      clk_cfg_reg  <= epm_pkg::EPM_PIN_CFG_RESET;
    end else if (cfg_load_i) begin
      data_cfg_reg <= data_pin_cfg_i;
      clk_cfg_reg  <= clock_pin_cfg_i;
    end
  end

  // pin mode decodes
  wire data_ee = (data_cfg_reg.mode == epm_pkg::EPM_MODE_EEPROM);
  wire clk_ee  = (clk_cfg_reg.mode == epm_pkg::EPM_MODE_EEPROM);

  // data pin output selection
  logic data_o_nx;
  logic data_oe_nx;

  always_comb begin
    data_o_nx  = 1'b0;
    data_oe_nx = 1'b1;
    case (data_cfg_reg.mode)
      epm_pkg::EPM_MODE_EEPROM: begin
        data_o_nx  = ee_core_i.data_out;
        data_oe_nx = ee_core_i.data_oe;
      end
      epm_pkg::EPM_MODE_GPO: begin
        data_o_nx = data_cfg_reg.gpo_value;
      end
      epm_pkg::EPM_MODE_MON_EN: begin
        data_o_nx = tx_en_s;
      end
      epm_pkg::EPM_MODE_MON_CLK: begin
        data_o_nx = tx_clk_s;
      end
      default: begin
        data_o_nx = 1'b0;
      end
    endcase
  end

  // clock pin output selection
  logic clk_o_nx;

  always_comb begin
    clk_o_nx = 1'b0;
    case (clk_cfg_reg.mode)
      epm_pkg::EPM_MODE_EEPROM:   clk_o_nx = ee_core_i.clock;
      epm_pkg::EPM_MODE_GPO:      clk_o_nx = clk_cfg_reg.gpo_value;
      epm_pkg::EPM_MODE_MON_EN:   clk_o_nx = rx_dv_s;
      epm_pkg::EPM_MODE_MON_CLK:  clk_o_nx = rx_clk_s;
      default:                    clk_o_nx = 1'b0;
    endcase
  end

  // select held off unless both pins carry the eeprom function
  wire sel_nx = ee_core_i.select & data_ee & clk_ee;

  // registered pin drivers
  logic data_o_reg;
  logic data_oe_reg;
  logic clk_o_reg;
  logic sel_reg;
  logic ee_din_reg;

  always_ff @(posedge clock_i) begin
    if (core_rst_reg) begin
      data_o_reg  <= 1'b0;
      data_oe_reg <= 1'b0;
      clk_o_reg   <= 1'b0;
      sel_reg     <= 1'b0;
      ee_din_reg  <= 1'b0;
    end else begin
      data_o_reg  <= data_o_nx;
      data_oe_reg <= data_oe_nx;
      clk_o_reg   <= clk_o_nx;
      sel_reg     <= sel_nx;
      ee_din_reg  <= data_ee & ee_din_s;
    end
  end

  // outputs
  assign eeprom_data_pin_o    = data_o_reg;
  assign eeprom_data_pin_oe_o = data_oe_reg;
  assign eeprom_clock_pin_o   = clk_o_reg;
  assign eeprom_select_o      = sel_reg;
  assign ee_data_in_o         = ee_din_reg;
  assign wake_indicator_o     = wake_out_reg;
  assign wake_indicator_oe_o  = wake_oe_reg;
  assign power_save_o         = (pwr_reg == ST_SLEEP);
  assign core_reset_o         = core_rst_reg;
  assign read_seen_o          = read_seen_reg;
  assign write_accept_o       = write_accept_reg;
  assign wake_write_o         = wake_write_reg;
  assign eth_defaults_o       = eth_reg;

endmodule

// file: design/epm_pkg.sv
// package: constants, types and defaults for the eeprom pin mux block
package epm_pkg;

  // function of a shared eeprom pin
  typedef enum logic [1:0] {
    EPM_MODE_EEPROM,
    EPM_MODE_GPO,
    EPM_MODE_MON_EN,
    EPM_MODE_MON_CLK
  } epm_pin_mode_t;

  // per-pin configuration field
  typedef struct packed {
    epm_pin_mode_t mode;
    logic          gpo_value;
  } epm_pin_cfg_t;

  // signals from the internal eeprom controller
  typedef struct packed {
    logic data_out;
    logic data_oe;
    logic clock;
    logic select;
  } epm_ee_core_t;

  // default ethernet settings derived from the strap
  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic autoneg_en;
  } epm_eth_defaults_t;

  // pin configuration after reset
  localparam epm_pin_cfg_t EPM_PIN_CFG_RESET = '{EPM_MODE_EEPROM, 1'b0};

  // settings selected by each strap level
  localparam epm_eth_defaults_t EPM_DEFAULTS_10  = '{1'b0, 1'b0, 1'b0};
  localparam epm_eth_defaults_t EPM_DEFAULTS_100 = '{1'b1, 1'b0, 1'b1};

  // synchroniser lane positions
  localparam int EPM_SYNC_W      = 10;
  localparam int EPM_S_HW_RST_N  = 0;
  localparam int EPM_S_CS_N      = 1;
  localparam int EPM_S_WR_N      = 2;
  localparam int EPM_S_RD_N      = 3;
  localparam int EPM_S_SPEED     = 4;
  localparam int EPM_S_EE_DIN    = 5;
  localparam int EPM_S_TX_EN     = 6;
  localparam int EPM_S_TX_CLK    = 7;
  localparam int EPM_S_RX_DV     = 8;
  localparam int EPM_S_RX_CLK    = 9;

  // synchroniser reset levels: strobes idle high, strap pulled up
  localparam logic [EPM_SYNC_W-1:0] EPM_SYNC_RESET = 10'h01f;

  // clock and reference timing
  localparam int EPM_CLOCK_HZ    = 100000000;
  localparam int EPM_REF_HZ      = 25000000;
  localparam int EPM_REF_DIV     = EPM_CLOCK_HZ / EPM_REF_HZ;
  localparam int EPM_POR_TICKS   = 16;

endpackage

// file: design/epm_sync2.sv
// two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module epm_sync2 #(
  parameter int              WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // first stage is read only by the second stage
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

// file: testbench/epm_far_model.sv
// far side model: host strobes, reset pin, strap and eeprom data line
`timescale 1ns/1ps
module epm_far_model (
  // clock and data pin drive from the block
  input  wire logic clock_i,
  input  wire logic data_drive_i,
  input  wire logic data_oe_i,
  // board pins toward the block
  output logic      hardware_reset_n_o,
  output logic      chip_select_n_o,
  output logic      write_strobe_n_o,
  output logic      read_strobe_n_o,
  output logic      speed_select_o,
  output logic      data_pin_o
);
  logic ee_bit;
  // pins rest at their pull-up levels
  initial begin
    hardware_reset_n_o = 1'b1;
    chip_select_n_o = 1'b1;
    write_strobe_n_o = 1'b1;
    read_strobe_n_o = 1'b1;
    speed_select_o = 1'b1;
    ee_bit = 1'b0;
  end
  // shared line: the block while it drives, else the eeprom
  assign data_pin_o = data_oe_i ? data_drive_i : ee_bit;
  // one host cycle, held well past the two-flop sync
  task automatic host_cycle(input logic is_write);
    @(negedge clock_i);
    chip_select_n_o = 1'b0; // writes stand for the byte test place
    write_strobe_n_o = !is_write;
    read_strobe_n_o = is_write;
    repeat (6) @(negedge clock_i);
    chip_select_n_o = 1'b1;
    write_strobe_n_o = 1'b1;
    read_strobe_n_o = 1'b1;
    repeat (6) @(negedge clock_i);
  endtask
endmodule

// file: testbench/epm_pin_mux_monitor.sv
// port assertions for the eeprom pin mux block
`timescale 1ns/1ps
module epm_pin_mux_monitor (
  // clock and reset
  input wire logic                       clock_i,
  input wire logic                       rst_i,
  // watched inputs
  input wire logic                       speed_select_i,
  input wire logic                       cfg_load_i,
  input wire epm_pkg::epm_pin_cfg_t      data_pin_cfg_i,
  input wire epm_pkg::epm_pin_cfg_t      clock_pin_cfg_i,
  input wire logic                       wake_event_i,
  input wire logic                       wake_enable_i,
  input wire logic                       wake_active_high_i,
  input wire logic                       wake_open_drain_i,
  // watched outputs
  input wire logic                       eeprom_data_pin_o,
  input wire logic                       eeprom_data_pin_oe_o,
  input wire logic                       eeprom_select_o,
  input wire logic                       wake_indicator_o,
  input wire logic                       wake_indicator_oe_o,
  input wire logic                       power_save_o,
  input wire logic                       core_reset_o,
  input wire logic                       read_seen_o,
  input wire logic                       write_accept_o,
  input wire logic                       wake_write_o,
  input wire epm_pkg::epm_eth_defaults_t eth_defaults_o
);
  logic alt_d;
  logic alt_c;
  logic ld;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // decoded load of an alternate pin function
  assign alt_d = data_pin_cfg_i.mode != epm_pkg::EPM_MODE_EEPROM;
  assign alt_c = clock_pin_cfg_i.mode != epm_pkg::EPM_MODE_EEPROM;
  assign ld = cfg_load_i && !core_reset_o;
  a_alt_no_select: assert property (ld && (alt_d || alt_c) |=> ##1
    !eeprom_select_o) else $error("select on in alternate mode");
  a_alt_drives_data: assert property (ld && alt_d |=> ##1
    eeprom_data_pin_oe_o) else $error("data pin not driven");
  a_gpo_data_value: assert property (ld && data_pin_cfg_i.mode ==
    epm_pkg::EPM_MODE_GPO |=> ##1
    eeprom_data_pin_o == $past(data_pin_cfg_i.gpo_value, 2))
    else $error("gpo value wrong");
  a_wake_push_pull: assert property (wake_event_i && wake_enable_i &&
    wake_active_high_i && !wake_open_drain_i && !core_reset_o |=> ##1
    wake_indicator_o && wake_indicator_oe_o) else $error("wake not shown");
  a_wake_open_drain: assert property (wake_event_i && wake_enable_i &&
    wake_open_drain_i && !core_reset_o |=> ##1 wake_indicator_oe_o)
    else $error("open drain wake not driven");
  a_sleep_exit_cause: assert property ($fell(power_save_o) |->
    wake_write_o || core_reset_o || $past(core_reset_o))
    else $error("sleep left without a write");
  a_wake_write_exit: assert property (wake_write_o |->
    !power_save_o && $past(power_save_o)) else $error("wake write bad");
  a_accept_after_read: assert property (write_accept_o |->
    read_seen_o && !power_save_o) else $error("write taken too early");
  a_reset_clears_all: assert property (core_reset_o |=>
    !read_seen_o && !power_save_o && !eeprom_select_o)
    else $error("core reset left state");
  a_strap_latched: assert property ($fell(core_reset_o) |-> ##3
    eth_defaults_o.speed_100 == speed_select_i &&
    eth_defaults_o.autoneg_en == speed_select_i &&
    !eth_defaults_o.full_duplex) else $error("strap defaults wrong");
  // main scenarios reached
  c_accept: cover property (write_accept_o);
  c_wake_write: cover property (wake_write_o);
  c_release: cover property ($fell(core_reset_o));
endmodule

bind epm_pin_mux epm_pin_mux_monitor u_epm_pin_mux_monitor (
  .clock_i, .rst_i, .speed_select_i, .cfg_load_i, .data_pin_cfg_i,
  .clock_pin_cfg_i, .wake_event_i, .wake_enable_i, .wake_active_high_i,
  .wake_open_drain_i, .eeprom_data_pin_o, .eeprom_data_pin_oe_o,
  .eeprom_select_o, .wake_indicator_o, .wake_indicator_oe_o, .power_save_o,
  .core_reset_o, .read_seen_o, .write_accept_o, .wake_write_o,
  .eth_defaults_o);

// file: testbench/epm_pin_mux_tb.sv
// self-checking bench for the eeprom pin mux block
`timescale 1ns/1ps
module epm_pin_mux_tb;
  localparam int TICKS = 2;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic hw_n, cs_n, wr_n, rd_n, strap, pin_in, pin_o, pin_oe, clk_pin;
  logic sel, ee_in, wk, wk_oe, ps, crst, rseen, acc, wwr, ld;
  logic tx_en, tx_clk, rx_dv, rx_clk;
  logic ps_in, wev, wen, wah, wod, wclr;
  epm_pkg::epm_ee_core_t ee_core;
  epm_pkg::epm_pin_cfg_t dcfg, ccfg;
  epm_pkg::epm_eth_defaults_t eth;
  int num_errors = 0;
  int checked = 0;
  int acc_cnt = 0;
  int wwr_cnt = 0;
  // 100 MHz clock
  always #5 clock_i = ~clock_i;
  // count one-cycle answer pulses where they are settled
  always @(negedge clock_i) begin
    if (acc === 1'b1) acc_cnt++;
    if (wwr === 1'b1) wwr_cnt++;
  end
  epm_pin_mux #(.POR_TICKS(TICKS)) u_epm_pin_mux (
    .clock_i(clock_i), .rst_i(rst_i), .hardware_reset_n_i(hw_n),
    .chip_select_n_i(cs_n), .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n),
    .speed_select_i(strap), .eeprom_data_pin_i(pin_in),
    .eeprom_data_pin_o(pin_o), .eeprom_data_pin_oe_o(pin_oe),
    .eeprom_clock_pin_o(clk_pin), .eeprom_select_o(sel),
    .ee_core_i(ee_core), .ee_data_in_o(ee_in), .mii_tx_en_i(tx_en),
    .mii_tx_clk_i(tx_clk), .mii_rx_dv_i(rx_dv), .mii_rx_clk_i(rx_clk),
    .cfg_load_i(ld), .data_pin_cfg_i(dcfg), .clock_pin_cfg_i(ccfg),
    .power_save_enter_i(ps_in), .wake_event_i(wev), .wake_enable_i(wen),
    .wake_active_high_i(wah), .wake_open_drain_i(wod),
    .wake_clear_i(wclr), .wake_indicator_o(wk), .wake_indicator_oe_o(wk_oe),
    .power_save_o(ps), .core_reset_o(crst), .read_seen_o(rseen),
    .write_accept_o(acc), .wake_write_o(wwr), .eth_defaults_o(eth));
  epm_far_model u_epm_far_model (
    .clock_i(clock_i), .data_drive_i(pin_o), .data_oe_i(pin_oe),
    .hardware_reset_n_o(hw_n), .chip_select_n_o(cs_n),
    .write_strobe_n_o(wr_n), .read_strobe_n_o(rd_n),
    .speed_select_o(strap), .data_pin_o(pin_in));
  // compare tasks
  task automatic check_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_vec(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // bounded wait for the end of core reset
  task automatic wait_ready();
    int n;
    n = 0;
    while (crst !== 1'b0 && n < 200) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 200) begin
      num_errors++;
      stop_test();
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clock_i);
    s = 1'b1;
    @(negedge clock_i);
    s = 1'b0;
    repeat (3) @(negedge clock_i);
  endtask
  task automatic load_cfg(input epm_pkg::epm_pin_mode_t dm,
                          input epm_pkg::epm_pin_mode_t cm, input logic v);
    @(negedge clock_i);
    dcfg = '{dm, v};
    ccfg = '{cm, v};
    ld = 1'b1;
    @(negedge clock_i);
    ld = 1'b0;
    repeat (5) @(negedge clock_i);
  endtask
  task automatic test_first_read();
    int a;
    a = acc_cnt;
    u_epm_far_model.host_cycle(1'b1);
    check_vec(8'(acc_cnt - a), 8'h00);
    u_epm_far_model.host_cycle(1'b0);
    check_bit(rseen, 1'b1);
    u_epm_far_model.host_cycle(1'b1);
    check_vec(8'(acc_cnt - a), 8'h01);
    $display("test first_read done");
  endtask
  task automatic test_default();
    ee_core = '{1'b1, 1'b0, 1'b1, 1'b1};
    u_epm_far_model.ee_bit = 1'b1;
    repeat (4) @(negedge clock_i);
    check_bit(sel, 1'b1);
    check_bit(clk_pin, 1'b1);
    check_bit(pin_oe, 1'b0);
    check_bit(ee_in, 1'b1);
    check_vec(8'(eth), 8'(epm_pkg::EPM_DEFAULTS_100));
    ee_core = '{1'b0, 1'b1, 1'b0, 1'b1};
    repeat (4) @(negedge clock_i);
    check_bit(pin_oe, 1'b1);
    check_bit(pin_o, 1'b0);
    check_bit(clk_pin, 1'b0);
    $display("test default done");
  endtask
  task automatic test_modes();
    for (int i = 1; i < 4; i++) begin
      for (int v = 0; v < 2; v++) begin
        // enable and data-valid opposite to the clocks: a swap shows
        {tx_en, tx_clk, rx_dv, rx_clk} = {v[0], !v[0], !v[0], v[0]};
        load_cfg(epm_pkg::epm_pin_mode_t'(i), epm_pkg::epm_pin_mode_t'(i),
                 v[0]);
        check_bit(pin_o, (i == 3) ? !v[0] : v[0]);
        check_bit(pin_oe, 1'b1);
        check_bit(ee_in, 1'b0);
        check_bit(clk_pin, (i == 2) ? !v[0] : v[0]);
        check_bit(sel, 1'b0);
      end
    end
    load_cfg(epm_pkg::EPM_MODE_GPO, epm_pkg::EPM_MODE_EEPROM, 1'b1);
    check_bit(sel, 1'b0);
    load_cfg(epm_pkg::EPM_MODE_EEPROM, epm_pkg::EPM_MODE_MON_EN, 1'b1);
    check_bit(sel, 1'b0);
    load_cfg(epm_pkg::EPM_MODE_EEPROM, epm_pkg::EPM_MODE_EEPROM, 1'b0);
    check_bit(sel, 1'b1);
    $display("test modes done");
  endtask
  task automatic test_wake();
    int a;
    int w;
    {wen, wah, wod} = 3'b010;
    pulse(wev);
    check_bit(wk, 1'b0);
    wen = 1'b1;
    pulse(wev);
    check_bit(wk, 1'b1);
    check_bit(wk_oe, 1'b1);
    pulse(wclr);
    {wah, wod} = 2'b01;
    pulse(wev);
    check_bit(wk, 1'b0);
    check_bit(wk_oe, 1'b1);
    pulse(wclr);
    check_bit(wk_oe, 1'b0);
    pulse(ps_in);
    pulse(wev);
    check_bit(ps, 1'b1);
    a = acc_cnt;
    w = wwr_cnt;
    u_epm_far_model.host_cycle(1'b1);
    check_bit(ps, 1'b0);
    check_vec(8'(wwr_cnt - w), 8'h01);
    u_epm_far_model.host_cycle(1'b1);
    check_vec(8'(acc_cnt - a), 8'h00);
    u_epm_far_model.host_cycle(1'b0);
    u_epm_far_model.host_cycle(1'b1);
    check_vec(8'(acc_cnt - a), 8'h01);
    $display("test wake done");
  endtask
  task automatic test_hw_reset();
    u_epm_far_model.speed_select_o = 1'b0;
    u_epm_far_model.hardware_reset_n_o = 1'b0;
    repeat (5) @(negedge clock_i);
    check_bit(crst, 1'b1);
    check_bit(rseen, 1'b0);
    check_bit(sel, 1'b0);
    u_epm_far_model.hardware_reset_n_o = 1'b1;
    wait_ready();
    repeat (4) @(negedge clock_i);
    check_vec(8'(eth), 8'(epm_pkg::EPM_DEFAULTS_10));
    u_epm_far_model.speed_select_o = 1'b1;
    repeat (4) @(negedge clock_i);
    check_vec(8'(eth), 8'(epm_pkg::EPM_DEFAULTS_10));
    $display("test hw_reset done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    {tx_en, tx_clk, rx_dv, rx_clk} = 4'h0;
    {ld, ps_in, wev, wen, wah, wod, wclr} = 7'h00;
    ee_core = '0;
    dcfg = epm_pkg::EPM_PIN_CFG_RESET;
    ccfg = epm_pkg::EPM_PIN_CFG_RESET;
    repeat (10) @(negedge clock_i);
    rst_i = 1'b0;
    repeat (4 * TICKS - 2) @(negedge clock_i);
    check_bit(crst, 1'b1);
    wait_ready();
    test_first_read();
    test_default();
    test_modes();
    test_wake();
    test_hw_reset();
    stop_test();
  end
endmodule
